// ### verilog/fcd_host.sv
// host controller issuing command sequences to a parallel nor flash
`default_nettype none
module fcd_host
    import fcd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_req,
    input wire logic [3:0] i_op,
    input wire logic i_byte_mode,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    output logic o_busy,
    output logic o_done,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_gap_late,
    output logic o_suspended,
    output logic o_bypass,
    output logic [ADDR_W-1:0] o_fa,
    output logic [DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [DATA_W-1:0] i_dq_in,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n
);
    typedef struct packed {
        logic rd;
        logic [11:0] a;
        logic use_user_a;
        logic [7:0] d;
        logic use_user_d;
    } fcd_cyc_t;

    fcd_state_t state;
    logic [2:0] idx;
    logic [2:0] nidx;
    logic [3:0] phase;
    logic [11:0] gap;
    logic gap_run;
    logic erasing;
    logic [3:0] op;
    logic bm;
    logic [ADDR_W-1:0] ua;
    logic [DATA_W-1:0] ud;

    function automatic logic [11:0] unl(input logic n, input logic b);
        if (n)
            return b ? UNL2_BYTE : UNL2_WORD;
        return b ? UNL1_BYTE : UNL1_WORD;
    endfunction

    function automatic fcd_cyc_t wr(input logic [11:0] a, input logic [7:0] d);
        fcd_cyc_t c;
        c = '0;
        c.a = a;
        c.d = d;
        return c;
    endfunction

    // one bus cycle of an operation; also returns the cycle count
    function automatic fcd_cyc_t step(input logic [3:0] o, input logic [2:0] i,
                                      input logic b, output logic [2:0] n);
        fcd_cyc_t c;
        c = '0;
        n = 3'h1;
        if (i == 3'h0)
            c = wr(unl(1'b0, b), CMD_UNLOCK1);
        else if (i == 3'h1)
            c = wr(unl(1'b1, b), CMD_UNLOCK2);
        unique case (o)
            OP_READ: begin
                c = '0;
                c.rd = 1'b1;
                c.use_user_a = 1'b1;
            end
            OP_RESET, OP_SUSPEND, OP_RESUME:
                c = wr(12'h000, o == OP_RESET ? CMD_RESET :
                                (o == OP_SUSPEND ? CMD_SUSPEND : CMD_RESUME));
            OP_QUERY:
                c = wr(b ? QRY_BYTE : QRY_WORD, CMD_QUERY);
            OP_IDREAD: begin
                n = 3'h4;
                if (i == 3'h2)
                    c = wr(unl(1'b0, b), CMD_AUTOSEL);
                else if (i == 3'h3) begin
                    c = '0;
                    c.rd = 1'b1;
                    c.use_user_a = 1'b1;
                end
            end
            OP_SECURED, OP_PROGRAM, OP_BYP_ENTER: begin
                n = (o == OP_PROGRAM) ? 3'h4 : 3'h3;
                if (i == 3'h2)
                    c = wr(unl(1'b0, b), o == OP_SECURED ? CMD_SECURED :
                           (o == OP_PROGRAM ? CMD_PROGRAM : CMD_BYPASS));
                else if (i == 3'h3) begin
                    c.use_user_a = 1'b1;
                    c.use_user_d = 1'b1;
                end
            end
            OP_BYP_PROG: begin
                n = 3'h2;
                c = wr(12'h000, CMD_PROGRAM);
                if (i == 3'h1) begin
                    c.use_user_a = 1'b1;
                    c.use_user_d = 1'b1;
                end
            end
            OP_BYP_EXIT: begin
                n = 3'h2;
                c = wr(12'h000, i == 3'h0 ? CMD_AUTOSEL : CMD_BYP_EXIT);
            end
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
                n = 3'h6;
                if (i == 3'h2)
                    c = wr(unl(1'b0, b), CMD_ERASE_SETUP);
                else if (i == 3'h3)
                    c = wr(unl(1'b0, b), CMD_UNLOCK1);
                else if (i == 3'h4)
                    c = wr(unl(1'b1, b), CMD_UNLOCK2);
                else if (i == 3'h5) begin
                    c = wr(unl(1'b0, b),
                           o == OP_CHIP_ERASE ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE);
                    c.use_user_a = (o == OP_SECT_ERASE);
                end
            end
            OP_SECT_MORE: begin
                c = wr(12'h000, CMD_SECTOR_ERASE);
                c.use_user_a = 1'b1;
            end
            default: c = wr(12'h000, CMD_RESET);
        endcase
        return c;
    endfunction

    fcd_cyc_t cur;
    always_comb begin
        cur = step(op, idx, bm, nidx);
    end

    logic legal;
    always_comb begin
        legal = 1'b1;
        if (i_op == OP_SUSPEND)
            legal = erasing && !o_suspended;
        else if (i_op == OP_RESUME)
            legal = o_suspended;
        else if (i_op == OP_SECT_MORE)
            legal = gap_run;
        else if (i_op == OP_BYP_PROG || i_op == OP_BYP_EXIT)
            legal = o_bypass;
        else if (i_op > OP_RESUME)
            legal = 1'b0;
    end

    // request capture and sequencing
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            idx <= 3'h0;
            phase <= 4'h0;
            op <= 4'h0;
            bm <= 1'b0;
            ua <= '0;
            ud <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (i_req && legal) begin
                        op <= i_op;
                        bm <= i_byte_mode;
                        ua <= i_addr;
                        ud <= i_data;
                        idx <= 3'h0;
                        phase <= PHASE_CYC;
                        o_busy <= 1'b1;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP, ST_STROBE, ST_HOLD: begin
                    if (phase > ONE)
                        phase <= phase - ONE;
                    else begin
                        phase <= PHASE_CYC;
                        if (state == ST_SETUP)
                            state <= ST_STROBE;
                        else if (state == ST_STROBE)
                            state <= ST_HOLD;
                        else if (idx + 3'h1 < nidx) begin
                            idx <= idx + 3'h1;
                            state <= ST_SETUP;
                        end else
                            state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // bus pins; address before strobe, data held past its rising edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fa <= '0;
            o_dq_out <= '0;
            o_dq_oe <= 1'b0;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_rdata <= '0;
        end else if (i_ce) begin
            if (state == ST_SETUP) begin
                // upper bits carry user value only where needed
                o_fa <= cur.use_user_a ? ua : {{(ADDR_W-12){1'b0}}, cur.a};
                o_dq_out <= cur.use_user_d ? ud : {8'h00, cur.d};
                o_dq_oe <= !cur.rd;
                o_ce_n <= 1'b0;
            end else if (state == ST_STROBE) begin
                o_we_n <= cur.rd;
                o_oe_n <= !cur.rd;
            end else if (state == ST_HOLD) begin
                // take read data while output enable still stands low
                if (!o_oe_n)
                    o_rdata <= i_dq_in;
                o_we_n <= 1'b1;
                o_oe_n <= 1'b1;
                if (phase == ONE) begin
                    o_ce_n <= 1'b1;
                    o_dq_oe <= 1'b0;
                end
            end
        end
    end

    // mode tracking
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bypass <= 1'b0;
            o_suspended <= 1'b0;
            erasing <= 1'b0;
        end else if (i_ce && state == ST_DONE) begin
            if (op == OP_BYP_ENTER)
                o_bypass <= 1'b1;
            else if (op == OP_BYP_EXIT || op == OP_RESET)
                o_bypass <= 1'b0;
            if (op == OP_SECT_ERASE)
                erasing <= 1'b1;
            else if (op == OP_RESET || op == OP_CHIP_ERASE)
                erasing <= 1'b0;
            if (op == OP_SUSPEND)
                o_suspended <= 1'b1;
            else if (op == OP_RESUME || op == OP_RESET)
                o_suspended <= 1'b0;
        end
    end

    // queue window for further sectors
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap <= 12'h000;
            gap_run <= 1'b0;
            o_gap_late <= 1'b0;
        end else if (i_ce) begin
            if (state == ST_DONE && (op == OP_SECT_ERASE || op == OP_SECT_MORE)) begin
                gap <= 12'(GAP_CYC - 1);
                gap_run <= 1'b1;
                o_gap_late <= 1'b0;
            end else if (gap_run && state == ST_IDLE) begin
                if (gap == 12'h000) begin
                    gap_run <= 1'b0;
                    o_gap_late <= 1'b1;
                end else
                    gap <= gap - 12'h001;
            end
        end
    end
endmodule
`default_nettype wire

// ### include/fcd_pkg.sv
// package for the flash command sequencer (host side)
`default_nettype none
package fcd_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_SECURED = 8'h88;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    // unlock and query addresses, word and byte mode
    localparam logic [11:0] UNL1_WORD = 12'h555;
    localparam logic [11:0] UNL2_WORD = 12'h2AA;
    localparam logic [11:0] UNL1_BYTE = 12'hAAA;
    localparam logic [11:0] UNL2_BYTE = 12'h555;
    localparam logic [11:0] QRY_WORD = 12'h055;
    localparam logic [11:0] QRY_BYTE = 12'h0AA;
    // identification read offsets
    localparam logic [11:0] ID_MAKER = 12'h000;
    localparam logic [11:0] ID_DEV_WORD = 12'h001;
    localparam logic [11:0] ID_DEV_BYTE = 12'h002;
    localparam logic [11:0] ID_PROT_WORD = 12'h002;
    localparam logic [11:0] ID_PROT_BYTE = 12'h004;
    localparam int SEC_LSB = 12;
    // bus timing in cycles
    localparam int CLK_MHZ = 50;
    localparam int PHASE_NS = 60;
    localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS * CLK_MHZ + 999) / 1000);
    localparam int GAP_US = 50;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam logic [3:0] ONE = 4'h1;
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_IDREAD = 4'h2, OP_SECURED = 4'h3,
        OP_QUERY = 4'h4, OP_PROGRAM = 4'h5, OP_BYP_ENTER = 4'h6, OP_BYP_PROG = 4'h7,
        OP_BYP_EXIT = 4'h8, OP_CHIP_ERASE = 4'h9, OP_SECT_ERASE = 4'hA,
        OP_SECT_MORE = 4'hB, OP_SUSPEND = 4'hC, OP_RESUME = 4'hD
    } fcd_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_STROBE = 3'b011,
        ST_HOLD = 3'b010, ST_DONE = 3'b110
    } fcd_state_t;
endpackage
`default_nettype wire

// ### sim/fcd_flash_model.sv
// behavioural flash device seen by the host sequencer
`default_nettype none
module fcd_flash_model
    import fcd_pkg::*;
#(
    parameter logic [7:0] MAKER = 8'h5E // arbitrary value
)
(
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [ADDR_W-1:0] i_fa,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [ADDR_W-1:0] la[$];
    logic [DATA_W-1:0] ld[$];
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] last = 16'h0000;
    logic idm = 1'h0;
    logic rdv = 1'h0;
    always @(negedge i_we_n) if (!i_ce_n) a = i_fa;
    always @(posedge i_we_n) if (!i_ce_n) begin
        la.push_back(a);
        ld.push_back(i_dq);
        if (i_dq[7:0] == CMD_RESET) idm = 1'h0;
        if (i_dq[7:0] == CMD_AUTOSEL && ld.size() > 1 && ld[ld.size()-2][7:0] == CMD_UNLOCK2)
            idm = 1'h1;
    end
    // id mode: maker at offset zero, else protect state of the sector
    assign rd = idm ? (i_fa[7:0] == 8'h00 ? {8'h00, MAKER} : {15'h0000, i_fa[SEC_LSB]}) :
                i_fa[15:0] ^ 16'hA5C3;
    always @(negedge i_oe_n) rdv = 1'h1;
    always @(posedge i_ce_n) begin
        rdv = 1'h0;
        last = rd;
    end
    // deselected: inverse of last data, never a stale match
    assign o_dq = (!i_ce_n && rdv) ? rd : ~last;
endmodule
`default_nettype wire

// ### sim/fcd_host_assertions.sv
// port checks for the host sequencer
`default_nettype none
module fcd_host_assertions
    import fcd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic [ADDR_W-1:0] o_fa,
    input wire logic [DATA_W-1:0] o_dq_out,
    input wire logic o_dq_oe,
    input wire logic o_ce_n,
    input wire logic o_we_n,
    input wire logic o_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    strobe_excl_a: assert property (o_we_n || o_oe_n)
        else $error("write and read strobes low together");
    write_drive_a: assert property (!o_we_n |-> !o_ce_n && o_dq_oe)
        else $error("write strobe without select or drive");
    read_release_a: assert property (!o_oe_n |-> !o_ce_n && !o_dq_oe)
        else $error("read strobe while driving data");
    strobe_width_a: assert property ($fell(o_we_n) |-> !o_we_n [*3] ##1 o_we_n)
        else $error("write strobe width wrong");
    latch_hold_a: assert property (!o_we_n |-> $stable(o_fa) && $stable(o_dq_out))
        else $error("address or data moved under strobe");
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    done_bound_a: assert property ($rose(o_busy) |-> ##[1:60] o_done)
        else $error("operation did not finish");
    done_idle_a: assert property (o_done |-> o_ce_n && o_we_n && o_oe_n && !o_dq_oe)
        else $error("bus not released at done");
    enable_freeze_a: assert property (!i_ce |=> $stable(o_fa) && $stable(o_we_n) && $stable(o_busy))
        else $error("state moved while disabled");
endmodule
bind fcd_host fcd_host_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .o_busy(o_busy), .o_done(o_done), .o_fa(o_fa), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
    .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n));
`default_nettype wire

// ### sim/fcd_host_tb.sv
// self-checking bench for the host sequencer
`default_nettype none
module fcd_host_tb
    import fcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MAKER = 8'h5E; // arbitrary value
    localparam logic [ADDR_W-1:0] ANY = 20'hFFFFF;
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, req = 1'h0, bm = 1'h0;
    logic [3:0] op = 4'h0;
    logic [ADDR_W-1:0] addr = 20'h00000, fa;
    logic [DATA_W-1:0] data = 16'h0000, rdata, dq_out, dq_in;
    logic busy, done, gap_late, susp, byp, dq_oe, ce_n, we_n, oe_n;
    int errors = 0, comparisons = 0;
    logic [ADDR_W-1:0] ea[$];
    logic [DATA_W-1:0] ed[$];
    always #10 clk = ~clk;
    fcd_host u_dut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_req(req), .i_op(op),
        .i_byte_mode(bm), .i_addr(addr), .i_data(data), .o_busy(busy), .o_done(done),
        .o_rdata(rdata), .o_gap_late(gap_late), .o_suspended(susp), .o_bypass(byp),
        .o_fa(fa), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_in), .o_ce_n(ce_n),
        .o_we_n(we_n), .o_oe_n(oe_n));
    fcd_flash_model #(.MAKER(MAKER)) u_flash (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_fa(fa), .i_dq(dq_out), .o_dq(dq_in));
    task automatic end_sim();
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        ea.push_back(a);
        ed.push_back(d);
    endtask
    // two unlock writes, then a command at the first unlock address
    task automatic ul(input logic [7:0] d);
        w(20'(bm ? UNL1_BYTE : UNL1_WORD), {8'h00, CMD_UNLOCK1});
        w(20'(bm ? UNL2_BYTE : UNL2_WORD), {8'h00, CMD_UNLOCK2});
        w(20'(bm ? UNL1_BYTE : UNL1_WORD), {8'h00, d});
    endtask
    // f cycles with the enable low during the setup phase
    task automatic run(input logic [3:0] o, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input int n, input int f);
        int k;
        k = 0;
        op = o;
        addr = a;
        data = d;
        req = 1'h1;
        // done of the previous call may still stand here
        do begin
            @(negedge clk);
            k++;
            if (busy === 1'h1) req = 1'h0;
            if (k == 2 && f > 0) ce = 1'h0;
            if (k == 2 + f && f > 0) ce = 1'h1;
        end while (done !== 1'h1 && k < 200);
        chk(k, 9 * n + 2 + f);
        chk(u_flash.la.size(), ea.size());
        foreach (ea[i]) begin
            if (ea[i] !== ANY) chk(u_flash.la[i], ea[i]);
            chk(u_flash.ld[i], ed[i]);
        end
        ea.delete();
        ed.delete();
        u_flash.la.delete();
        u_flash.ld.delete();
    endtask
    task automatic refuse(input logic [3:0] o);
        op = o;
        req = 1'h1;
        repeat (4) @(negedge clk);
        chk(busy, 1'h0);
        req = 1'h0;
        @(negedge clk);
    endtask
    task automatic s_read();
        run(OP_READ, 20'h4A5B6, 16'h0000, 1, 0);
        chk(rdata, 16'hA5B6 ^ 16'hA5C3);
    endtask
    task automatic s_cmds();
        ul(CMD_AUTOSEL);
        run(OP_IDREAD, 20'h00000, 16'h0000, 4, 0);
        chk(rdata, {8'h00, MAKER});
        ul(CMD_AUTOSEL);
        run(OP_IDREAD, 20'h01000 | 20'(bm ? ID_PROT_BYTE : ID_PROT_WORD), 16'h0000, 4, 0);
        chk(rdata, 16'h0001);
        ul(CMD_AUTOSEL);
        run(OP_IDREAD, 20'h02000 | 20'(bm ? ID_PROT_BYTE : ID_PROT_WORD), 16'h0000, 4, 0);
        chk(rdata, 16'h0000);
        w(ANY, {8'h00, CMD_RESET});
        run(OP_RESET, 20'h00000, 16'h0000, 1, 0);
        w(20'(bm ? QRY_BYTE : QRY_WORD), {8'h00, CMD_QUERY});
        run(OP_QUERY, 20'h00000, 16'h0000, 1, 0);
        ul(CMD_SECURED);
        run(OP_SECURED, 20'h00000, 16'h0000, 3, 0);
        ul(CMD_PROGRAM);
        w(20'hF1234, 16'hBE5F);
        run(OP_PROGRAM, 20'hF1234, 16'hBE5F, 4, bm ? 0 : 6);
    endtask
    task automatic s_bypass();
        ul(CMD_BYPASS);
        run(OP_BYP_ENTER, 20'h00000, 16'h0000, 3, 0);
        chk(byp, 1'h1);
        w(ANY, {8'h00, CMD_PROGRAM});
        w(20'h2468A, 16'h1357);
        run(OP_BYP_PROG, 20'h2468A, 16'h1357, 2, 0);
        w(ANY, {8'h00, CMD_AUTOSEL});
        w(ANY, {8'h00, CMD_BYP_EXIT});
        run(OP_BYP_EXIT, 20'h00000, 16'h0000, 2, 0);
        chk(byp, 1'h0);
        refuse(OP_BYP_PROG);
    endtask
    task automatic s_erase();
        ul(CMD_ERASE_SETUP);
        ul(CMD_CHIP_ERASE);
        run(OP_CHIP_ERASE, 20'h00000, 16'h0000, 6, 0);
        refuse(OP_SUSPEND);
        ul(CMD_ERASE_SETUP);
        ul(CMD_SECTOR_ERASE);
        ea[5] = 20'h3F000;
        run(OP_SECT_ERASE, 20'h3F000, 16'h0000, 6, 0);
        w(20'h5A000, {8'h00, CMD_SECTOR_ERASE});
        run(OP_SECT_MORE, 20'h5A000, 16'h0000, 1, 0);
        w(ANY, {8'h00, CMD_SUSPEND});
        run(OP_SUSPEND, 20'h00000, 16'h0000, 1, 0);
        chk(susp, 1'h1);
        refuse(OP_SUSPEND);
        ul(CMD_PROGRAM);
        w(20'h01230, 16'h00C3);
        run(OP_PROGRAM, 20'h01230, 16'h00C3, 4, 0);
        w(ANY, {8'h00, CMD_RESUME});
        run(OP_RESUME, 20'h00000, 16'h0000, 1, 0);
        chk(susp, 1'h0);
        refuse(OP_RESUME);
        repeat (GAP_CYC + 100) @(negedge clk);
        chk(gap_late, 1'h1);
        refuse(OP_SECT_MORE);
    endtask
    initial begin
        #400000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        s_read();
        s_cmds();
        bm = 1'h1;
        s_cmds();
        bm = 1'h0;
        s_bypass();
        s_erase();
        end_sim();
    end
endmodule
`default_nettype wire
